// File: logic/lcd_control_command_decoder.sv
// command decoder for the control commands of a dot-matrix lcd driver
// assumes one clock, async active-high reset, AHB-Lite slave port, zero wait states
// How it works
// - bias bit zero 1/9, one 1/7
// - bias applied only with follower enabled
// - rmw: writes advance column, reads hold
// - end leaves rmw, restores saved column
// - software reset restores listed defaults, clears modes
// - scan direction from D3, low bits ignored
// - power bits enable booster, regulator, follower
// - ratio loads three low bits
// - contrast mode accepts only contrast byte
// - contrast byte loads six low bits
// - contrast written, normal acceptance resumes
// - indicator lsb: off single, on two-byte
// - indicator on accepts only register byte
// - indicator changed only by indicator commands and resets
// - indicator byte loads two low bits
`timescale 1ns/1ps
module lcd_control_command_decoder
    import lcdcmd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output lcdcmd_settings_t settings,
    output logic biasApplied,
    output logic [7:0] columnAddr,
    output logic [3:0] pageAddr,
    output logic [5:0] startLine
);

////////////////////////////////////////////////////////////////////////////////
// bus address phase capture

logic wrPend_reg;
logic [7:0] addr_reg;
logic [1:0] dummyTrans;
assign dummyTrans = htrans;

// latch a write address phase; data comes in the next cycle
always_ff @(posedge ref_clk or posedge reset)
begin
    if (reset)
    begin
        wrPend_reg <= 1'b0;
        addr_reg <= 8'h00;
    end
    else
    begin
        wrPend_reg <= hsel && hready && dummyTrans[1] && hwrite;
        if (hsel && hready && dummyTrans[1])
            addr_reg <= haddr[7:0];
    end
end

assign hreadyout = 1'b1;  // never stalls, so the host has no wait to count
assign hresp = 1'b0;

// byte strobes from the data phase
logic cmdStrobe;
logic dataWrite;
logic dataRead;
logic ctrlWrite;
logic [7:0] bytev;
assign bytev = hwdata[7:0];
assign cmdStrobe = wrPend_reg && addr_reg == ADDR_CMD && !hwdata[CMD_SEL_BIT];
assign dataWrite = wrPend_reg && addr_reg == ADDR_CMD && hwdata[CMD_SEL_BIT]
    && !hwdata[DATA_READ_BIT];
assign dataRead = wrPend_reg && addr_reg == ADDR_CMD && hwdata[CMD_SEL_BIT]
    && hwdata[DATA_READ_BIT];
assign ctrlWrite = wrPend_reg && addr_reg == ADDR_CTRL;

////////////////////////////////////////////////////////////////////////////////
// command decode

// masked opcode match, shared by every decoder below
function automatic logic opMatch(input logic [7:0] b, input logic [7:0] op,
    input logic [7:0] mask);
    opMatch = (b & mask) == (op & mask);
endfunction

logic isBias, isRmw, isEnd, isSwReset, isScan, isPower, isRatio;
logic isContrast, isIndicator, isColHi, isColLo, isPage, isStart, isTest;
assign isBias = opMatch(bytev, OP_BIAS, 8'hFE);
assign isRmw = opMatch(bytev, OP_RMW, 8'hFF);
assign isEnd = opMatch(bytev, OP_END, 8'hFF);
assign isSwReset = opMatch(bytev, OP_SWRESET, 8'hFF);
assign isScan = opMatch(bytev, OP_SCAN, 8'hF0);
assign isPower = opMatch(bytev, OP_POWER, 8'hF8);
assign isRatio = opMatch(bytev, OP_RATIO, 8'hF8);
assign isContrast = opMatch(bytev, OP_CONTRAST, 8'hFF);
assign isIndicator = opMatch(bytev, OP_INDICATOR, 8'hFE);
assign isColHi = opMatch(bytev, OP_COLHI, 8'hF0);
assign isColLo = opMatch(bytev, OP_COLLO, 8'hF0);
assign isPage = opMatch(bytev, OP_PAGE, 8'hF0);
assign isStart = opMatch(bytev, OP_START, 8'hC0);
assign isTest = opMatch(bytev, OP_TEST, 8'hF0);

lcdcmd_state_t state_reg;
logic normalCmd;
logic swReset;
assign normalCmd = cmdStrobe && state_reg == LCDCMD_IDLE;
assign swReset = normalCmd && isSwReset;

// two-byte sequence tracking
always_ff @(posedge ref_clk or posedge reset)
begin
    if (reset)
        state_reg <= LCDCMD_IDLE;
    else if (cmdStrobe)
    begin
        case (state_reg)
            LCDCMD_IDLE:
            begin
                if (isContrast)
                    state_reg <= LCDCMD_WAIT_CONTRAST;
                else if (isIndicator && bytev[0])
                    state_reg <= LCDCMD_WAIT_INDICATOR;
            end
            LCDCMD_WAIT_CONTRAST: state_reg <= LCDCMD_IDLE;
            LCDCMD_WAIT_INDICATOR: state_reg <= LCDCMD_IDLE;
            default: state_reg <= LCDCMD_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// settings

// bias, scan, power stages and ratio
always_ff @(posedge ref_clk or posedge reset)
begin
    if (reset)
    begin
        settings.biasSeventh <= 1'b0;
        settings.scanReverse <= 1'b0;
        settings.boostOn <= 1'b0;
        settings.regulatorOn <= 1'b0;
        settings.followerOn <= 1'b0;
        settings.ratio <= RATIO_RST;
    end
    else if (swReset)
    begin
        settings.scanReverse <= 1'b0;
        settings.ratio <= RATIO_RST;
    end
    else if (normalCmd)
    begin
        if (isBias)
            settings.biasSeventh <= bytev[0];
        if (isScan)
            settings.scanReverse <= bytev[SCAN_BIT];
        if (isPower)
        begin
            settings.boostOn <= bytev[BOOST_BIT];
            settings.regulatorOn <= bytev[REG_BIT];
            settings.followerOn <= bytev[FOLLOW_BIT];
        end
        if (isRatio)
            settings.ratio <= bytev[2:0];
    end
    else if (ctrlWrite)
    begin
        // software may also drive the stages directly
        settings.boostOn <= hwdata[BOOST_BIT];
        settings.regulatorOn <= hwdata[REG_BIT];
        settings.followerOn <= hwdata[FOLLOW_BIT];
    end
end

// bias only reaches the panel while the follower runs; 1/9 otherwise
assign biasApplied = settings.followerOn && settings.biasSeventh;

// contrast register
always_ff @(posedge ref_clk or posedge reset)
begin
    if (reset)
        settings.contrast <= CONTRAST_RST;
    else if (swReset)
        settings.contrast <= CONTRAST_RST;
    else if (cmdStrobe && state_reg == LCDCMD_WAIT_CONTRAST)
        settings.contrast <= bytev[5:0];
end

// indicator: only the indicator commands and the resets touch it
always_ff @(posedge ref_clk or posedge reset)
begin
    if (reset)
        settings.indicator <= IND_RST;
    else if (swReset)
        settings.indicator <= IND_RST;
    else if (cmdStrobe && state_reg == LCDCMD_WAIT_INDICATOR)
        settings.indicator <= bytev[1:0];
    else if (normalCmd && isIndicator && !bytev[0])
        settings.indicator <= IND_RST;
end

// test mode: entered by the test command, left only by a reset
always_ff @(posedge ref_clk or posedge reset)
begin
    if (reset)
        settings.testMode <= 1'b0;
    else if (swReset)
        settings.testMode <= 1'b0;
    else if (normalCmd && isTest)
        settings.testMode <= 1'b1;
end

////////////////////////////////////////////////////////////////////////////////
// addresses and read-modify-write

logic [7:0] savedCol_reg;

// rmw flag and the column saved on entry
always_ff @(posedge ref_clk or posedge reset)
begin
    if (reset)
    begin
        settings.rmwActive <= 1'b0;
        savedCol_reg <= COL_RST;
    end
    else if (swReset)
        settings.rmwActive <= 1'b0;
    else if (normalCmd && isRmw)
    begin
        settings.rmwActive <= 1'b1;
        savedCol_reg <= columnAddr;
    end
    else if (normalCmd && isEnd)
        settings.rmwActive <= 1'b0;
end

// column counter stops at its top value
always_ff @(posedge ref_clk or posedge reset)
begin
    if (reset)
        columnAddr <= COL_RST;
    else if (swReset)
        columnAddr <= COL_RST;
    else if (normalCmd && isEnd && settings.rmwActive)
        columnAddr <= savedCol_reg;
    else if (normalCmd && isColHi)
        columnAddr <= {bytev[3:0], columnAddr[3:0]};  // assumed not during rmw
    else if (normalCmd && isColLo)
        columnAddr <= {columnAddr[7:4], bytev[3:0]};
    else if ((dataWrite || (dataRead && !settings.rmwActive)) && columnAddr != 8'hFF)
        columnAddr <= columnAddr + 8'h01;
end

// page and start line
always_ff @(posedge ref_clk or posedge reset)
begin
    if (reset)
    begin
        pageAddr <= PAGE_RST;
        startLine <= START_RST;
    end
    else if (swReset)
    begin
        pageAddr <= PAGE_RST;
        startLine <= START_RST;
    end
    else if (normalCmd && isPage)
        pageAddr <= bytev[3:0];
    else if (normalCmd && isStart)
        startLine <= bytev[5:0];
end

////////////////////////////////////////////////////////////////////////////////
// read data

// registered read data, valid in the data phase after the address phase
always_ff @(posedge ref_clk or posedge reset)
begin
    if (reset)
        hrdata <= 32'h00000000;
    else if (hsel && hready && dummyTrans[1] && !hwrite)
    begin
        case (haddr[7:0])
            ADDR_STATE: hrdata <= {12'h000, state_reg, settings};
            ADDR_ADDRS: hrdata <= {14'h0000, startLine, pageAddr, columnAddr};
            ADDR_CTRL: hrdata <= {29'h0, settings.boostOn, settings.regulatorOn,
                settings.followerOn};
            default: hrdata <= 32'h00000000;
        endcase
    end
end

endmodule

// File: logic/lcdcmd_pkg.sv
// package for the lcd control command decoder: opcodes, field positions, reset values
// assumes a single 40 MHz clock domain and an AHB-Lite register port
package lcdcmd_pkg;
    // command opcodes (full byte or masked prefix)
    localparam logic [7:0] OP_BIAS = 8'hA2;       // low bit is the ratio
    localparam logic [7:0] OP_RMW = 8'hE0;
    localparam logic [7:0] OP_END = 8'hEE;
    localparam logic [7:0] OP_SWRESET = 8'hE2;
    localparam logic [7:0] OP_SCAN = 8'hC0;       // upper nibble C, D3 direction
    localparam logic [7:0] OP_POWER = 8'h28;      // 0010_1xxx
    localparam logic [7:0] OP_RATIO = 8'h20;      // 0010_0xxx
    localparam logic [7:0] OP_CONTRAST = 8'h81;
    localparam logic [7:0] OP_INDICATOR = 8'hAC;  // low bit on/off
    localparam logic [7:0] OP_COLHI = 8'h10;      // 0001_xxxx
    localparam logic [7:0] OP_COLLO = 8'h00;      // 0000_xxxx
    localparam logic [7:0] OP_PAGE = 8'hB0;       // 1011_xxxx
    localparam logic [7:0] OP_START = 8'h40;      // 01xx_xxxx
    localparam logic [7:0] OP_TEST = 8'hF0;       // 1111_xxxx
    // field positions
    localparam int SCAN_BIT = 3;
    localparam int BOOST_BIT = 2;
    localparam int REG_BIT = 1;
    localparam int FOLLOW_BIT = 0;
    // reset values
    localparam logic [2:0] RATIO_RST = 3'h0;
    localparam logic [5:0] CONTRAST_RST = 6'h20;
    localparam logic [1:0] IND_RST = 2'h0;
    localparam logic [7:0] COL_RST = 8'h00;
    localparam logic [3:0] PAGE_RST = 4'h0;
    localparam logic [5:0] START_RST = 6'h00;
    // register byte addresses
    localparam logic [7:0] ADDR_CMD = 8'h00;      // write: command/data byte
    localparam logic [7:0] ADDR_STATE = 8'h04;    // read: settings
    localparam logic [7:0] ADDR_ADDRS = 8'h08;    // read: column/page/start line
    localparam logic [7:0] ADDR_CTRL = 8'h0C;     // write: power stage enables
    localparam int CMD_SEL_BIT = 8;                // command_data_select in write data
    localparam int DATA_READ_BIT = 9;              // marks a display data read
    // decoder states
    typedef enum logic [1:0]
    {
        LCDCMD_IDLE = 2'b00,
        LCDCMD_WAIT_CONTRAST = 2'b01,
        LCDCMD_WAIT_INDICATOR = 2'b10
    } lcdcmd_state_t;
    // settings carried to the panel side
    typedef struct packed
    {
        logic biasSeventh;
        logic scanReverse;
        logic boostOn;
        logic regulatorOn;
        logic followerOn;
        logic [2:0] ratio;
        logic [5:0] contrast;
        logic [1:0] indicator;
        logic rmwActive;
        logic testMode;
    } lcdcmd_settings_t;
endpackage

// File: tb/lcdcmd_host.sv
// host model: single-word AHB-Lite transfers that carry lcd command and data bytes
// assumes one slave whose hreadyout is fed back as hready
`timescale 1ns/1ps
module lcdcmd_host
    import lcdcmd_pkg::*;
(
    input logic ref_clk,
    input logic hready,
    input logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic hung
);
////////////////////////////////////////
    // quiet bus from time zero; word size never changes
    initial
    begin
        {hsel, haddr, htrans, hwrite, hwdata, hung} = '0;
        hsize = 3'h2;
    end
    // bounded wait for hready high at an edge; running out raises hung
    task automatic waitReady();
        int n;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (hready !== 1'b1 && n < 64);
        if (hready !== 1'b1)
            hung <= 1'b1;
    endtask
    // one transfer; released data shows the inverse so stale values never match
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge ref_clk);
        {hsel, haddr, htrans, hwrite} <= {1'b1, 24'h0, a, 2'h2, wr};
        waitReady();
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        waitReady();
        q = hrdata;
        hwdata <= ~d;
    endtask
    // command byte: select bit low
    task automatic cmd(input logic [7:0] b);
        logic [31:0] q;
        xfer(1'b1, ADDR_CMD, {24'h0, b}, q);
    endtask
    // display data write (rd low) or read (rd high)
    task automatic data(input logic rd, input logic [7:0] b);
        logic [31:0] q;
        xfer(1'b1, ADDR_CMD, {22'h0, rd, 1'b1, b}, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask
endmodule

// File: tb/lcdcmd_monitor.sv
// checker for the lcd command decoder, watching its top ports only
// assumes a zero-wait slave; bound into every decoder instance
`timescale 1ns/1ps
module lcdcmd_monitor
    import lcdcmd_pkg::*;
(
    input logic ref_clk,
    input logic reset,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [31:0] hwdata,
    input logic hready,
    input lcdcmd_settings_t settings,
    input logic biasApplied,
    input logic [7:0] columnAddr
);
////////////////////////////////////////
    logic wrPend;
    logic waitC;
    logic waitI;
    wire isCmd = wrPend && !hwdata[CMD_SEL_BIT];
    wire idleCmd = isCmd && !waitC && !waitI;
    wire [7:0] cb = hwdata[7:0];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // data phase of a write to the command address
    always_ff @(posedge ref_clk or posedge reset)
        if (reset)
            wrPend <= 1'b0;
        else
            wrPend <= hready && hsel && htrans[1] && hwrite && haddr == {24'h0, ADDR_CMD};
    // own copy of the two-byte state, so a stuck state in the design shows
    always_ff @(posedge ref_clk or posedge reset)
        if (reset)
            {waitC, waitI} <= 2'b00;
        else if (isCmd)
            {waitC, waitI} <= {idleCmd && cb == OP_CONTRAST, idleCmd && cb == 8'hAD};
////////////////////////////////////////
    a_bias_select:
        assert property (idleCmd && cb[7:1] == 7'h51 |=> settings.biasSeventh == $past(cb[0]))
        else $error("bias ratio not taken from bit zero");
    a_bias_gate:
        assert property (biasApplied == (settings.biasSeventh && settings.followerOn))
        else $error("bias applied without follower");
    a_power_bits:
        assert property (idleCmd && cb[7:3] == 5'h05 |=>
            {settings.boostOn, settings.regulatorOn, settings.followerOn} == $past(cb[2:0]))
        else $error("power stage bits wrong");
    a_contrast_only:
        assert property (isCmd && waitC |=> settings.contrast == $past(cb[5:0])
            && $stable(settings.biasSeventh) && $stable(settings.ratio))
        else $error("contrast byte not loaded alone");
    a_ind_value:
        assert property (isCmd && waitI |=> settings.indicator == $past(cb[1:0])
            && $stable(settings.scanReverse))
        else $error("indicator byte not loaded alone");
    a_ind_alone:
        assert property (idleCmd && cb[7:1] != 7'h56 && cb != OP_SWRESET |=>
            $stable(settings.indicator))
        else $error("indicator moved by another command");
    a_rmw_step:
        assert property (wrPend && hwdata[9:8] == 2'b01 && settings.rmwActive
            && columnAddr != 8'hFF |=> columnAddr == $past(columnAddr) + 8'h01)
        else $error("column did not step on write");
    a_soft_reset:
        assert property (idleCmd && cb == OP_SWRESET |=> settings.contrast == CONTRAST_RST
            && settings.indicator == IND_RST && !settings.rmwActive && columnAddr == COL_RST)
        else $error("software reset left state behind");
    c_contrast: cover property (isCmd && waitC);
    c_indicator: cover property (isCmd && waitI);
    c_rmw_write: cover property (wrPend && hwdata[9:8] == 2'b01 && settings.rmwActive);
endmodule
bind lcd_control_command_decoder lcdcmd_monitor i_lcdcmd_monitor (.ref_clk, .reset, .hsel,
    .haddr, .htrans, .hwrite, .hwdata, .hready, .settings, .biasApplied, .columnAddr);

// File: tb/tb.sv
// self-checking bench for the lcd command decoder
// assumes the host model drives the bus and the monitor is bound in
`timescale 1ns/1ps
module tb
    import lcdcmd_pkg::*;
;
    typedef struct {logic [7:0] b; logic [17:0] s;} lcdcmd_row_t;
    logic ref_clk;
    logic reset;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    lcdcmd_settings_t settings;
    logic biasApplied;
    logic [7:0] columnAddr;
    logic hung;
    logic [31:0] q;
    int fails;
    int totalChecks;
    // two-byte pairs go back to back 81 then 20 is the idle value
    lcdcmd_row_t rows [22] = '{'{8'hA3, 18'h20200}, '{8'hA2, 18'h00200}, '{8'hA3, 18'h20200},
        '{8'hC8, 18'h30200}, '{8'hC7, 18'h20200}, '{8'h2D, 18'h2A200}, '{8'h2A, 18'h24200},
        '{8'h27, 18'h25E00}, '{8'h20, 18'h24200}, '{8'h81, 18'h24200}, '{8'hA2, 18'h24220},
        '{8'hA2, 18'h04220}, '{8'hAD, 18'h04220}, '{8'hFE, 18'h04228}, '{8'hAC, 18'h04220},
        '{8'hAD, 18'h04220}, '{8'h27, 18'h0422C}, '{8'h81, 18'h0422C}, '{8'h20, 18'h0420C},
        '{8'hE0, 18'h0420E}, '{8'hF0, 18'h0420F}, '{8'hE2, 18'h04200}};
////////////////////////////////////////
    lcdcmd_host i_lcdcmd_host (.ref_clk, .hready(hreadyout), .hrdata, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hung);
    lcd_control_command_decoder i_lcd_control_command_decoder (.ref_clk, .reset, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
        .hresp, .hrdata, .settings, .biasApplied, .columnAddr, .pageAddr(), .startLine());
    // 40 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // a stuck bus ends the run as a failure
    always @(posedge ref_clk)
        if (hung === 1'b1)
        begin
            fails++;
            conclude();
        end
////////////////////////////////////////
    // hardware reset first, then the command table, then the awkward cases
    initial
    begin
        fails = 0;
        totalChecks = 0;
        reset = 1'b1;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        #1;
        check("reset settings", {14'h0, settings}, 32'h00000200);
        foreach (rows[i])
        begin
            i_lcdcmd_host.cmd(rows[i].b);
            #1;
            check("settings", {14'h0, settings},
                {14'h0, rows[i].s});
            check("biasApplied", {31'h0, biasApplied},
                {31'h0, rows[i].s[17] & rows[i].s[13]});
        end
        // column 25, then steps in rmw; no column set until the end command
        i_lcdcmd_host.cmd(8'h12);
        i_lcdcmd_host.cmd(8'h05);
        i_lcdcmd_host.cmd(OP_RMW);
        i_lcdcmd_host.data(1'b0, 8'h5A);
        i_lcdcmd_host.data(1'b0, 8'hA5);
        i_lcdcmd_host.data(1'b1, 8'h00);
        #1;
        check("rmw column", {24'h0, columnAddr}, 32'h00000027);
        i_lcdcmd_host.cmd(OP_END);
        #1;
        check("end column", {24'h0, columnAddr}, 32'h00000025);
        i_lcdcmd_host.rd(ADDR_ADDRS, q);
        check("address word", q, 32'h00000025);
        i_lcdcmd_host.rd(8'h10, q);
        check("unmapped read", q, 32'h00000000);
        // software reset in mid rmw clears the mode and the column
        i_lcdcmd_host.cmd(OP_RMW);
        i_lcdcmd_host.cmd(OP_SWRESET);
        #1;
        check("swreset settings", {14'h0, settings}, 32'h00004200);
        check("swreset column", {24'h0, columnAddr}, 32'h00000000);
        // state word while the contrast byte is pending, then the byte itself
        i_lcdcmd_host.cmd(OP_CONTRAST);
        i_lcdcmd_host.rd(ADDR_STATE, q);
        check("state word", q, 32'h00044200);
        i_lcdcmd_host.cmd(8'h3F);
        #1;
        check("contrast", {14'h0, settings}, 32'h000043F0);
        // page and start line reach the address word
        i_lcdcmd_host.cmd(8'hB3);
        i_lcdcmd_host.cmd(8'h45);
        i_lcdcmd_host.rd(ADDR_ADDRS, q);
        check("page and start", q, 32'h00005300);
        // stages through the control word, then bias reaches the panel
        i_lcdcmd_host.xfer(1'b1, ADDR_CTRL, 32'h00000007, q);
        i_lcdcmd_host.rd(ADDR_CTRL, q);
        check("power word", q, 32'h00000007);
        i_lcdcmd_host.cmd(8'hA3);
        #1;
        check("bias on follower", {31'h0, biasApplied}, 32'h00000001);
        check("hresp", {31'h0, hresp}, 32'h00000000);
        // hardware reset in mid run clears the power stages too
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        #1;
        check("hw reset settings", {14'h0, settings}, 32'h00000200);
        i_lcdcmd_host.rd(ADDR_ADDRS, q);
        check("hw reset addresses", q, 32'h00000000);
        conclude();
    end
endmodule
